/* File: src/synth_serial_consts.svh */
`ifndef SYNTH_SERIAL_CONSTS_SVH
`define SYNTH_SERIAL_CONSTS_SVH

`define SHIFT_WIDTH        32
`define SEL_MSB            2
`define SEL_FREQ           3'h0
`define SEL_FRACTIONAL_NUMERATOR_PHASE     3'h1
`define SEL_DIVIDER        3'h2
`define SEL_FUNCTION       3'h3
`define SEL_CLOCK          3'h4
`define SEL_DEVIATION      3'h5
`define SEL_STEP           3'h6
`define SEL_DELAY          3'h7
`define FREQ_RAMP_ON_BIT   31
`define FREQ_MUX_MSB       30
`define FREQ_MUX_LSB       27
`define FREQ_INT_MSB       26
`define FREQ_INT_LSB       15
`define FREQ_FMSB_MSB      14
`define FREQ_FMSB_LSB      3
`define FP_PHASE_EN_BIT    28
`define FP_FLSB_MSB        27
`define FP_FLSB_LSB        15
`define FP_PHASE_MSB       14
`define FP_PHASE_LSB       3
`define FRACTIONAL_NUMERATOR_LOW_WIDTH     13
`define FN_PSK_BIT         9
`define FN_FSK_BIT         8
`define FN_LDP_BIT         7
`define FN_PD_POL_BIT      6
`define FN_PWR_DOWN_BIT    5
`define FN_CP_HIZ_BIT      4
`define FN_CNT_RESET_BIT   3
`define WORD_RESET         32'h0000_0000

`endif

/* File: src/synth_serial_pkg.sv */
package synth_serial_pkg;
    typedef logic [31:0] word_t;
    typedef struct packed {
        logic        ramp_on;
        logic [3:0]  test_mux_select;
        logic [11:0] integer_value;
        logic [24:0] fractional_numerator;
        logic        phase_adjust_enable;
        logic [11:0] phase_word;
    } freq_cfg_s;
    typedef struct packed {
        logic psk_enable;
        logic fsk_enable;
        logic lock_detect_precision;
        logic pd_polarity;
        logic power_down;
        logic cp_three_state;
        logic counter_reset;
    } func_cfg_s;
endpackage

/* File: src/synth_serial_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "synth_serial_consts.svh"

module synth_serial_register_bank (
    // system
    input  wire logic                       clk,
    input  wire logic                       rst,
    // serial link
    input  wire logic                       serial_clk,
    input  wire logic                       serial_data,
    input  wire logic                       latch_load_strobe,
    // decoded settings
    output var synth_serial_pkg::freq_cfg_s freq_cfg,
    output var synth_serial_pkg::func_cfg_s func_cfg,
    output var synth_serial_pkg::word_t     divider_word,
    output var synth_serial_pkg::word_t     clock_and_sigma_delta_word,
    output var synth_serial_pkg::word_t     deviation_word,
    output var synth_serial_pkg::word_t     ramp_step_word,
    output var synth_serial_pkg::word_t     ramp_delay_word,
    output var logic                        freq_word_written
);
    import synth_serial_pkg::*;

    // link domain: shifter runs on the serial clock only
    word_t shift_reg;
    word_t shift_next;

    always_comb begin
        shift_next = {shift_reg[`SHIFT_WIDTH-2:0], serial_data};
    end

    always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
            shift_reg <= `WORD_RESET;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // strobe, resampled in clk domain through three flops
    logic [2:0] strobe_sync_reg;
    logic [2:0] strobe_sync_next;
    logic       strobe_level_reg;
    logic       strobe_level_next;
    logic       load_pulse;

    always_comb begin
        strobe_sync_next  = {strobe_sync_reg[1:0], latch_load_strobe};
        strobe_level_next = strobe_level_reg;
        if (strobe_sync_reg[2] == strobe_sync_reg[1]) begin
            strobe_level_next = strobe_sync_reg[2];
        end
        // act on the settled rising edge of the strobe
        load_pulse = strobe_level_next & ~strobe_level_reg;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobe_sync_reg  <= 3'h0;
            strobe_level_reg <= 1'b0;
        end else begin
            strobe_sync_reg  <= strobe_sync_next;
            strobe_level_reg <= strobe_level_next;
        end
    end

    // the shifted word is stable while the strobe is high (host stops the
    // serial clock around the strobe), so sampling it here is a safe
    // handshake-style word crossing without extra capture flops
    word_t load_word;
    logic [`SEL_MSB:0] load_sel;
    assign load_word = shift_reg;
    assign load_sel  = load_word[`SEL_MSB:0];

    // latches and double-buffer holding stage
    word_t freq_word_reg,       freq_word_next;
    word_t fractional_numerator_phase_reg,      fractional_numerator_phase_next;
    word_t fractional_numerator_phase_act_reg,  fractional_numerator_phase_act_next;
    word_t divider_reg,         divider_next;
    word_t divider_act_reg,     divider_act_next;
    word_t function_reg,        function_next;
    word_t clock_reg,           clock_next;
    word_t deviation_reg,       deviation_next;
    word_t step_reg,            step_next;
    word_t delay_reg,           delay_next;
    logic  freq_pulse_reg,      freq_pulse_next;

    always_comb begin
        freq_word_next      = freq_word_reg;
        fractional_numerator_phase_next     = fractional_numerator_phase_reg;
        fractional_numerator_phase_act_next = fractional_numerator_phase_act_reg;
        divider_next        = divider_reg;
        divider_act_next    = divider_act_reg;
        function_next       = function_reg;
        clock_next          = clock_reg;
        deviation_next      = deviation_reg;
        step_next           = step_reg;
        delay_next          = delay_reg;
        freq_pulse_next     = 1'b0;
        if (load_pulse) begin
            case (load_sel)
                `SEL_FREQ: begin
                    freq_word_next      = load_word;
                    freq_pulse_next     = 1'b1;
                    fractional_numerator_phase_act_next = fractional_numerator_phase_reg;
                    divider_act_next    = divider_reg;
                end
                // fraction-low and phase store, held pending
                `SEL_FRACTIONAL_NUMERATOR_PHASE: fractional_numerator_phase_next = load_word;
                `SEL_DIVIDER:    divider_next    = load_word;
                `SEL_FUNCTION:   function_next   = load_word;
                // clock word is not double-buffered: it goes out at once
                `SEL_CLOCK:      clock_next      = load_word;
                `SEL_DEVIATION:  deviation_next  = load_word;
                `SEL_STEP:       step_next       = load_word;
                `SEL_DELAY:      delay_next      = load_word;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freq_word_reg      <= `WORD_RESET;
            fractional_numerator_phase_reg     <= `WORD_RESET;
            fractional_numerator_phase_act_reg <= `WORD_RESET;
            divider_reg        <= `WORD_RESET;
            divider_act_reg    <= `WORD_RESET;
            function_reg       <= `WORD_RESET;
            clock_reg          <= `WORD_RESET;
            deviation_reg      <= `WORD_RESET;
            step_reg           <= `WORD_RESET;
            delay_reg          <= `WORD_RESET;
            freq_pulse_reg     <= 1'b0;
        end else begin
            freq_word_reg      <= freq_word_next;
            fractional_numerator_phase_reg     <= fractional_numerator_phase_next;
            fractional_numerator_phase_act_reg <= fractional_numerator_phase_act_next;
            divider_reg        <= divider_next;
            divider_act_reg    <= divider_act_next;
            function_reg       <= function_next;
            clock_reg          <= clock_next;
            deviation_reg      <= deviation_next;
            step_reg           <= step_next;
            delay_reg          <= delay_next;
            freq_pulse_reg     <= freq_pulse_next;
        end
    end

    // decoded outputs, registered so each port comes from a flop
    freq_cfg_s freq_cfg_reg, freq_cfg_next;
    func_cfg_s func_cfg_reg, func_cfg_next;

    always_comb begin
        freq_cfg_next.ramp_on = freq_word_reg[`FREQ_RAMP_ON_BIT];
        freq_cfg_next.test_mux_select =
            freq_word_reg[`FREQ_MUX_MSB:`FREQ_MUX_LSB];
        freq_cfg_next.integer_value =
            freq_word_reg[`FREQ_INT_MSB:`FREQ_INT_LSB];
        // numerator = msb part << 13 + lsb part
        freq_cfg_next.fractional_numerator =
            {freq_word_reg[`FREQ_FMSB_MSB:`FREQ_FMSB_LSB],
             {`FRACTIONAL_NUMERATOR_LOW_WIDTH{1'b0}}}
            + {12'h000, fractional_numerator_phase_act_reg[`FP_FLSB_MSB:`FP_FLSB_LSB]};
        freq_cfg_next.phase_adjust_enable =
            fractional_numerator_phase_act_reg[`FP_PHASE_EN_BIT];
        // phase word, step = word*360/4096 downstream
        freq_cfg_next.phase_word =
            fractional_numerator_phase_act_reg[`FP_PHASE_MSB:`FP_PHASE_LSB];
        func_cfg_next.psk_enable            = function_reg[`FN_PSK_BIT];
        func_cfg_next.fsk_enable            = function_reg[`FN_FSK_BIT];
        func_cfg_next.lock_detect_precision = function_reg[`FN_LDP_BIT];
        func_cfg_next.pd_polarity           = function_reg[`FN_PD_POL_BIT];
        func_cfg_next.power_down     = function_reg[`FN_PWR_DOWN_BIT];
        func_cfg_next.cp_three_state = function_reg[`FN_CP_HIZ_BIT];
        func_cfg_next.counter_reset  = function_reg[`FN_CNT_RESET_BIT];
    end

    word_t div_out_reg, clk_out_reg, dev_out_reg, step_out_reg, delay_out_reg;
    logic  freq_written_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freq_cfg_reg     <= '0;
            func_cfg_reg     <= '0;
            div_out_reg      <= `WORD_RESET;
            clk_out_reg      <= `WORD_RESET;
            dev_out_reg      <= `WORD_RESET;
            step_out_reg     <= `WORD_RESET;
            delay_out_reg    <= `WORD_RESET;
            freq_written_reg <= 1'b0;
        end else begin
            freq_cfg_reg     <= freq_cfg_next;
            func_cfg_reg     <= func_cfg_next;
            div_out_reg      <= divider_act_reg;
            clk_out_reg      <= clock_reg;
            dev_out_reg      <= deviation_reg;
            step_out_reg     <= step_reg;
            delay_out_reg    <= delay_reg;
            freq_written_reg <= freq_pulse_reg;
        end
    end

    assign freq_cfg                   = freq_cfg_reg;
    assign func_cfg                   = func_cfg_reg;
    assign divider_word               = div_out_reg;
    assign clock_and_sigma_delta_word = clk_out_reg;
    assign deviation_word             = dev_out_reg;
    assign ramp_step_word             = step_out_reg;
    assign ramp_delay_word            = delay_out_reg;
    assign freq_word_written          = freq_written_reg;

    // a load as the checks below see it, one per select of interest
    sequence freq_load_seq;
        load_pulse && load_sel == `SEL_FREQ;
    endsequence
    sequence fractional_numerator_load_seq;
        load_pulse && load_sel == `SEL_FRACTIONAL_NUMERATOR_PHASE;
    endsequence

    // each link clock rise moves the word one place toward the msb
    a_shift_msb_first: assert property (
        @(posedge serial_clk) disable iff (rst)
        ##1 shift_reg == {$past(shift_reg[`SHIFT_WIDTH-2:0]),
                          $past(serial_data)})
        else $error("shift register did not take the new bit at the lsb");
    // a settled strobe rise writes the selected latch
    a_latch_select: assert property (
        @(posedge clk) disable iff (rst)
        load_pulse && load_sel == `SEL_STEP |=> step_reg == $past(load_word))
        else $error("step latch not written on its select");
    // the clock word is not held back, it goes out on its own load
    a_clock_direct: assert property (
        @(posedge clk) disable iff (rst)
        load_pulse && load_sel == `SEL_CLOCK
        |=> ##1 clock_and_sigma_delta_word == $past(load_word, 2))
        else $error("clock word not passed out after its load");
    // a frequency store is marked by the written pulse
    a_freq_store: assert property (
        @(posedge clk) disable iff (rst)
        freq_load_seq |=> freq_pulse_reg ##1 freq_written_reg)
        else $error("frequency store did not raise the written pulse");
    // the written mark lasts one cycle only
    a_written_pulse: assert property (
        @(posedge clk) disable iff (rst)
        freq_written_reg |=> !freq_written_reg)
        else $error("written pulse held for more than one cycle");
    // the active fraction copy moves only on a frequency write
    a_pending_hold: assert property (
        @(posedge clk) disable iff (rst)
        !freq_pulse_next |=> $stable(fractional_numerator_phase_act_reg))
        else $error("active fraction copy moved without a frequency write");
    // a frequency write makes the pending divider word live
    a_divider_apply: assert property (
        @(posedge clk) disable iff (rst)
        freq_load_seq |=> ##1 divider_word == $past(divider_reg, 2))
        else $error("pending divider word not applied by a frequency write");
    // a fraction-low store lands but stays pending
    a_fractional_numerator_store: assert property (
        @(posedge clk) disable iff (rst)
        fractional_numerator_load_seq |=> fractional_numerator_phase_reg == $past(load_word)
            && $stable(fractional_numerator_phase_act_reg))
        else $error("fraction-low store lost or applied early");
    // pending phase settings go live on a freq write
    a_phase_apply: assert property (
        @(posedge clk) disable iff (rst)
        freq_load_seq |=> ##1 freq_cfg_reg.phase_word ==
            $past(fractional_numerator_phase_reg[`FP_PHASE_MSB:`FP_PHASE_LSB], 2)
            && freq_cfg_reg.phase_adjust_enable ==
            $past(fractional_numerator_phase_reg[`FP_PHASE_EN_BIT], 2))
        else $error("pending phase settings not applied by a frequency write");
    // the test mux select comes from the stored frequency word
    a_mux_select: assert property (
        @(posedge clk) disable iff (rst)
        freq_load_seq |=> ##1 freq_cfg_reg.test_mux_select ==
            $past(load_word[`FREQ_MUX_MSB:`FREQ_MUX_LSB], 2))
        else $error("test mux select differs from the stored word");
    // the integer value comes from the stored frequency word
    a_int_value: assert property (
        @(posedge clk) disable iff (rst)
        freq_load_seq |=> ##1 freq_cfg_reg.integer_value ==
            $past(load_word[`FREQ_INT_MSB:`FREQ_INT_LSB], 2))
        else $error("integer value differs from the stored word");
    // upper part times 2^13 plus lower part
    a_numerator_sum: assert property (
        @(posedge clk) disable iff (rst)
        ##1 freq_cfg_reg.fractional_numerator ==
            {$past(freq_word_reg[14:3]), $past(fractional_numerator_phase_act_reg[27:15])})
        else $error("fractional numerator not formed from its two parts");
    // ramp bit follows the frequency word
    a_ramp_on: assert property (
        @(posedge clk) disable iff (rst)
        ##1 freq_cfg_reg.ramp_on == $past(freq_word_reg[31]))
        else $error("ramp enable differs from the frequency word");
    // psk bit follows the function word
    a_psk_bit: assert property (
        @(posedge clk) disable iff (rst)
        ##1 func_cfg_reg.psk_enable == $past(function_reg[9]))
        else $error("psk enable differs from the function word");
    // power-down bit follows the function word
    a_power_down: assert property (
        @(posedge clk) disable iff (rst)
        ##1 func_cfg_reg.power_down == $past(function_reg[5]))
        else $error("power-down differs from the function word");
endmodule
`default_nettype wire

/* File: verification/serial_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_host_model (
    // link pins driven by the host
    output var logic serial_clk,
    output var logic serial_data,
    output var logic latch_load_strobe
);
    initial begin
        serial_clk        = 1'b0;
        serial_data       = 1'b0;
        latch_load_strobe = 1'b0;
    end

    // one frame; the link clock (125 ns) only toggles inside a frame
    task automatic send_word(input logic [31:0] w);
        integer i;
        // odd offset keeps the link out of phase with the system clock
        #3.1;
        for (i = 31; i >= 0; i--) begin
            serial_data = w[i];
            #62.5 serial_clk = 1'b1;
            #62.5 serial_clk = 1'b0;
        end
        // data line no longer meaningful once the frame is over
        serial_data = ~w[0];
        #62.5 latch_load_strobe = 1'b1;
        // held well past the four system cycles the synchroniser needs
        #250 latch_load_strobe = 1'b0;
        #250;
    endtask
endmodule

`default_nettype wire

/* File: verification/test_synth_serial_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "synth_serial_consts.svh"

module test_synth_serial_register_bank;
    import synth_serial_pkg::*;

    typedef struct packed {
        word_t w;
        word_t exp;
    } row_s;

    localparam word_t FREQ_A  = 32'hb2a5_c7f8;
    localparam word_t FREQ_B  = 32'h4d5a_3800;
    localparam word_t FP_W    = 32'h1abc_d551;
    localparam word_t CLOCK_W = 32'h8765_4324;
    localparam word_t DIV_W   = 32'h1357_9bda;

    logic       clk       = 1'b0;
    logic       rst       = 1'b1;
    wire logic  serial_clk;
    wire logic  serial_data;
    wire logic  latch_load_strobe;
    freq_cfg_s  freq_cfg;
    func_cfg_s  func_cfg;
    word_t      divider_word;
    word_t      clock_and_sigma_delta_word;
    word_t      deviation_word;
    word_t      ramp_step_word;
    word_t      ramp_delay_word;
    logic       freq_word_written;
    int         error_cnt = 0;
    int         compares  = 0;
    int         pulses    = 0;
    row_s       rows [7];

    always #10 clk = ~clk;

    synth_serial_register_bank dut_u (
        .clk                        (clk),
        .rst                        (rst),
        .serial_clk                 (serial_clk),
        .serial_data                (serial_data),
        .latch_load_strobe          (latch_load_strobe),
        .freq_cfg                   (freq_cfg),
        .func_cfg                   (func_cfg),
        .divider_word               (divider_word),
        .clock_and_sigma_delta_word (clock_and_sigma_delta_word),
        .deviation_word             (deviation_word),
        .ramp_step_word             (ramp_step_word),
        .ramp_delay_word            (ramp_delay_word),
        .freq_word_written          (freq_word_written)
    );

    serial_host_model host_u (
        .serial_clk        (serial_clk),
        .serial_data       (serial_data),
        .latch_load_strobe (latch_load_strobe)
    );

    // a held level instead of a pulse would inflate this count
    always @(posedge clk) begin
        if (freq_word_written === 1'b1) begin
            pulses++;
        end
    end

    task automatic check(input string name, input logic [63:0] seen,
                         input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [63:0] seen_of(input logic [2:0] sel);
        case (sel)
            `SEL_FUNCTION:  return 64'(func_cfg);
            `SEL_CLOCK:     return 64'(clock_and_sigma_delta_word);
            `SEL_DEVIATION: return 64'(deviation_word);
            `SEL_STEP:      return 64'(ramp_step_word);
            `SEL_DELAY:     return 64'(ramp_delay_word);
            default:        return 64'(divider_word);
        endcase
    endfunction

    task automatic check_freq(input word_t f, input word_t p);
        logic [24:0] num;
        num = (25'(f[`FREQ_FMSB_MSB:`FREQ_FMSB_LSB]) << 13)
            + 25'(p[`FP_FLSB_MSB:`FP_FLSB_LSB]);
        check("ramp_on", 64'(freq_cfg.ramp_on), 64'(f[31]));
        check("mux", 64'(freq_cfg.test_mux_select), 64'(f[30:27]));
        check("int", 64'(freq_cfg.integer_value), 64'(f[26:15]));
        check("fractional_numerator", 64'(freq_cfg.fractional_numerator), 64'(num));
        check("ph_en", 64'(freq_cfg.phase_adjust_enable), 64'(p[28]));
        check("phase", 64'(freq_cfg.phase_word), 64'(p[14:3]));
    endtask

    task automatic print_verdict;
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        rows[0] = '{32'h0002_035b, 32'h0000_006b};
        rows[1] = '{32'h0002_0283, 32'h0000_0050};
        rows[2] = '{CLOCK_W, CLOCK_W};
        rows[3] = '{32'h0abc_de05, 32'h0abc_de05};
        rows[4] = '{32'h00fe_dcbe, 32'h00fe_dcbe};
        rows[5] = '{32'h007a_5a5f, 32'h007a_5a5f};
        rows[6] = '{DIV_W, 32'h0000_0000};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            host_u.send_word(rows[i].w);
            check("row", seen_of(rows[i].w[2:0]), 64'(rows[i].exp));
        end
        // pending words go live together with the frequency word
        host_u.send_word(FREQ_A);
        check("clock", 64'(clock_and_sigma_delta_word), 64'(CLOCK_W));
        check("divider", 64'(divider_word), 64'(DIV_W));
        check("pulses", 64'(pulses), 64'd1);
        check_freq(FREQ_A, 32'h0);
        // fraction and phase stay pending until the next frequency word
        host_u.send_word(FP_W);
        check_freq(FREQ_A, 32'h0);
        host_u.send_word(FREQ_B);
        check_freq(FREQ_B, FP_W);
        check("pulses", 64'(pulses), 64'd2);
        // reset in mid-run clears every setting
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        check("rst_freq", 64'(freq_cfg), 64'h0);
        check("rst_func", 64'(func_cfg), 64'h0);
        check("rst_dev", 64'(deviation_word), 64'h0);
        check("rst_clk", 64'(clock_and_sigma_delta_word), 64'h0);
        rst <= 1'b0;
        @(posedge clk);
        host_u.send_word(FREQ_A);
        check("clk_after", 64'(clock_and_sigma_delta_word), 64'h0);
        check_freq(FREQ_A, 32'h0);
        check("pulses", 64'(pulses), 64'd3);
        print_verdict;
    end

    // about 11 frames of 4.6 us each; allow several times that
    initial begin
        #500000;
        error_cnt++;
        print_verdict;
    end
endmodule

`default_nettype wire
